// ==== verilog/sgio_defs.svh ====
`ifndef SGIO_DEFS_SVH
`define SGIO_DEFS_SVH
// ==========================================================
// timing
`define SGIO_CLK_NS          25
`define SGIO_SERVO_NS        120000
`define SGIO_SERVO_CYCLES    (`SGIO_SERVO_NS / `SGIO_CLK_NS)
`define SGIO_AVG_WIN_NS      5000000
`define SGIO_AVG_WIN_TICKS   (`SGIO_AVG_WIN_NS / `SGIO_SERVO_NS)
`define SGIO_AVG_SHIFT       5
// ==========================================================
// register indices
`define SGIO_A_DIR           4'h0
`define SGIO_A_CMD           4'h1
`define SGIO_A_OUT           4'h2
`define SGIO_A_DEB           4'h3
`define SGIO_A_KILL          4'h4
`define SGIO_A_STOP          4'h5
`define SGIO_A_ANA           4'h6
`define SGIO_A_HS            4'h7
`define SGIO_A_STAT          4'h8
`define SGIO_A_MASK          4'h9
`define SGIO_A_ASEL          4'hA
`define SGIO_A_ADAT          4'hB
// ==========================================================
// status bits
`define SGIO_ST_KILL         0
`define SGIO_ST_STOP         1
`define SGIO_ST_TRIG         2
`define SGIO_ST_ERR          3
// ==========================================================
// field positions
`define SGIO_F_CMD_OP_LSB    4
`define SGIO_F_CMD_LEVEL     6
`define SGIO_F_CMD_OUTPUT    7
`define SGIO_F_DEB_LSB       8
`define SGIO_F_KILL_POL_LSB  4
`define SGIO_F_TRIG_EN       8
`define SGIO_F_TRIG_POL      9
`define SGIO_F_STOP_POL      3
`define SGIO_N_LINES         7
`define SGIO_N_CHAN          12
`endif

// ==== verilog/sgio_pkg.sv ====
package sgio_pkg;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_CONFIG,
    OP_SET,
    OP_CLEAR
  } sgio_op_t;
  typedef logic [15:0] sgio_word_t;
endpackage

// ==== verilog/sgio_lines.sv ====
// Overview of operation
// - after reset every line is an input, no output driven
// - config command touches one line, may make it output with start level
// - set command makes line an output driven high, even from input use
// - clear command same as set but drives low
// - set or clear on a high-speed line is refused and flags an error
// - digital input change accepted after persisting programmed servo ticks
// - only lines 1..3 can kill motor; kill stops motor at once
// - each kill trigger has selectable active level
// - stop condition uses a line that is plain input only
// - line 1 can trigger scaled encoder output, filtered like other inputs
// - lines 4..7 single-ended analog; 4-5 and 6-7 differential pairs
// - single-ended samples 10 bit, differential 11 bit
// - results scaled to 16 bit: 0..32767 single, signed differential
// - differential value is difference of simultaneous samples of the pair
// - twelve analog channels: four single, two differential, six internal
// - device never starts link traffic; outputs are its only signal
// - each analog channel averaged with a 32-tick time constant (3.84 ms), refreshed every servo tick
`timescale 1ns/1ps
`default_nettype none
`include "sgio_defs.svh"

module sgio_lines #(
  parameter int SERVO_CYCLES = `SGIO_SERVO_CYCLES
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic [6:0]  LINE_IN,
  output logic      [6:0]  LINE_OUT,
  output logic      [6:0]  LINE_OE,
  input  wire logic [6:0]  HS_BUSY,
  input  wire logic [39:0] ADC_LINE,
  input  wire logic [59:0] ADC_INT,
  output logic             SERVO_TICK,
  output logic             MOTOR_KILL,
  output logic             MOTION_STOP,
  output logic             SCALED_TRIG,
  output logic             IRQ
);

  // ========================================================
  // servo tick
  logic [15:0] tick_cnt;
  logic        tick;
  assign tick       = (tick_cnt == 16'(SERVO_CYCLES - 1));
  assign SERVO_TICK = tick;

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN || tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // ========================================================
  // command decode
  logic               wr_cmd;
  logic [2:0]         cmd_line;
  logic [6:0]         cmd_mask;
  sgio_pkg::sgio_op_t cmd_op;
  logic               cmd_hit;
  logic               cmd_err;
  logic               cmd_ok;
  assign wr_cmd   = WR && (ADDR == `SGIO_A_CMD);
  assign cmd_line = WDATA[2:0];
  assign cmd_mask = (cmd_line == 3'h0) ? 7'h00 : 7'(7'h01 << (cmd_line - 3'h1));
  assign cmd_op   = sgio_pkg::sgio_op_t'(WDATA[`SGIO_F_CMD_OP_LSB +: 2]);
  assign cmd_hit  = wr_cmd && (cmd_op != sgio_pkg::OP_NONE) && (cmd_mask != 7'h00);
  assign cmd_err  = cmd_hit && ((cmd_mask & HS_BUSY) != 7'h00);
  assign cmd_ok   = cmd_hit && !cmd_err;

  // ========================================================
  // direction and output level
  logic [6:0] dir;
  logic [6:0] out_lvl;
  assign LINE_OE  = dir;
  assign LINE_OUT = out_lvl;

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      dir     <= 7'h00;
      out_lvl <= 7'h00;
    end else if (cmd_ok) begin
      unique case (cmd_op)
        sgio_pkg::OP_CONFIG: begin
          if (WDATA[`SGIO_F_CMD_OUTPUT]) begin
            dir     <= dir | cmd_mask;
            out_lvl <= WDATA[`SGIO_F_CMD_LEVEL] ? (out_lvl | cmd_mask)
                                                : (out_lvl & ~cmd_mask);
          end else begin
            dir <= dir & ~cmd_mask;
          end
        end
        sgio_pkg::OP_SET: begin
          dir     <= dir | cmd_mask;
          out_lvl <= out_lvl | cmd_mask;
        end
        sgio_pkg::OP_CLEAR: begin
          dir     <= dir | cmd_mask;
          out_lvl <= out_lvl & ~cmd_mask;
        end
        sgio_pkg::OP_NONE: begin
          dir <= dir;
        end
      endcase
    end
  end

  // ========================================================
  // analog use of lines 4..7
  logic [3:0] ana_en;
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ana_en <= 4'h0;
    end else if (WR && (ADDR == `SGIO_A_ANA)) begin
      ana_en <= WDATA[3:0];
    end else if (cmd_ok && (cmd_op != sgio_pkg::OP_CONFIG
                            || WDATA[`SGIO_F_CMD_OUTPUT])) begin
      // an output no longer serves as analog input
      ana_en <= ana_en & ~cmd_mask[6:3];
    end
  end

  // ========================================================
  // debounce, one counter per line
  logic [7:0] deb_cnt [7];
  logic [6:0] filt;
  logic       wr_deb;
  assign wr_deb = WR && (ADDR == `SGIO_A_DEB);

  genvar gi;
  generate
    for (gi = 0; gi < `SGIO_N_LINES; gi++) begin : g_deb
      logic [7:0] limit;
      logic [7:0] run;
      always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
          limit <= 8'h00;
        end else if (wr_deb && (cmd_line == 3'(gi + 1))) begin
          limit <= WDATA[`SGIO_F_DEB_LSB +: 8];
        end
      end
      always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
          run      <= 8'h00;
          filt[gi] <= 1'b0;
        end else if (tick) begin
          if (LINE_IN[gi] == filt[gi]) begin
            run <= 8'h00;
          end else if (run >= limit) begin
            filt[gi] <= LINE_IN[gi];
            run      <= 8'h00;
          end else begin
            run <= run + 8'h01;
          end
        end
      end
      assign deb_cnt[gi] = limit;
    end
  endgenerate

  // ========================================================
  // kill, stop and trigger configuration
  logic [9:0] kill_cfg;
  logic [3:0] stop_cfg;
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      kill_cfg <= 10'h000;
      stop_cfg <= 4'h0;
    end else if (WR && (ADDR == `SGIO_A_KILL)) begin
      kill_cfg <= WDATA[9:0];
    end else if (WR && (ADDR == `SGIO_A_STOP)) begin
      stop_cfg <= WDATA[3:0];
    end
  end

  logic [6:0] plain_in;
  logic [2:0] kill_hit;
  logic       kill_cond;
  logic       stop_cond;
  logic       trig_lvl;
  logic       trig_prev;
  assign plain_in = ~dir & ~HS_BUSY & ~{ana_en, 3'b000};
  assign kill_hit  = kill_cfg[2:0] & plain_in[2:0]
                   & ~(filt[2:0] ^ kill_cfg[`SGIO_F_KILL_POL_LSB +: 3]);
  assign kill_cond = |kill_hit;
  // stop line must be plain input
  assign stop_cond = (stop_cfg[2:0] != 3'h0)
                   && plain_in[stop_cfg[2:0] - 3'h1]
                   && (filt[stop_cfg[2:0] - 3'h1] == stop_cfg[`SGIO_F_STOP_POL]);
  // line 1 trigger on filtered level
  assign trig_lvl  = kill_cfg[`SGIO_F_TRIG_EN] && plain_in[0]
                   && (filt[0] == kill_cfg[`SGIO_F_TRIG_POL]);

  // kill also ends motion, so the stop output follows it
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      MOTOR_KILL  <= 1'b0;
      MOTION_STOP <= 1'b0;
      SCALED_TRIG <= 1'b0;
      trig_prev   <= 1'b0;
    end else begin
      MOTOR_KILL  <= kill_cond;
      MOTION_STOP <= stop_cond || kill_cond;
      SCALED_TRIG <= trig_lvl && !trig_prev;
      trig_prev   <= trig_lvl;
    end
  end

  // ========================================================
  // analog filtering: 12 channels, 5 fraction bits = x32 scale
  logic signed [11:0] chan_in [12];
  logic signed [16:0] avg     [12];
  generate
    for (gi = 0; gi < 4; gi++) begin : g_single
      assign chan_in[gi] = $signed({2'b00, ADC_LINE[gi*10 +: 10]});
    end
    for (gi = 0; gi < 2; gi++) begin : g_diff
      assign chan_in[4+gi] = $signed({2'b00, ADC_LINE[gi*20 +: 10]})
                           - $signed({2'b00, ADC_LINE[gi*20+10 +: 10]});
    end
    for (gi = 0; gi < 6; gi++) begin : g_int
      assign chan_in[6+gi] = $signed({2'b00, ADC_INT[gi*10 +: 10]});
    end
    for (gi = 0; gi < `SGIO_N_CHAN; gi++) begin : g_avg
      logic signed [17:0] err;
      assign err = 18'(chan_in[gi] * 32) - 18'(avg[gi]);
      // per-tick update of the running average
      always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
          avg[gi] <= 17'sh00000;
        end else if (tick) begin
          avg[gi] <= avg[gi] + 17'(err >>> `SGIO_AVG_SHIFT);
        end
      end
    end
  endgenerate

  logic [3:0]  asel;
  logic [15:0] ana_word;
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      asel <= 4'h0;
    end else if (WR && (ADDR == `SGIO_A_ASEL)) begin
      asel <= WDATA[3:0];
    end
  end
  always_comb begin
    ana_word = 16'h0000;
    if (asel < 4'(`SGIO_N_CHAN)) begin
      if (avg[asel] > 17'sd32767) begin
        ana_word = 16'h7FFF;
      end else if (avg[asel] < -17'sd32768) begin
        ana_word = 16'h8000;
      end else begin
        ana_word = avg[asel][15:0];
      end
    end
  end

  // ========================================================
  // interrupts
  logic [3:0] status;
  logic [3:0] mask;
  logic [3:0] st_set;
  logic [3:0] st_clr;
  logic       kill_q;
  logic       stop_q;
  assign st_set = {cmd_err, SCALED_TRIG, stop_cond && !stop_q,
                   kill_cond && !kill_q};
  assign st_clr = (WR && (ADDR == `SGIO_A_STAT)) ? WDATA[3:0] : 4'h0;
  assign IRQ    = |(status & mask);

  // set wins over a same-cycle clear
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      status <= 4'h0;
      mask   <= 4'h0;
      kill_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      status <= (status & ~st_clr) | st_set;
      kill_q <= kill_cond;
      stop_q <= stop_cond;
      if (WR && (ADDR == `SGIO_A_MASK)) begin
        mask <= WDATA[3:0];
      end
    end
  end

  // ========================================================
  // read port; the device only answers, never initiates
  // answer-only access
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      unique case (ADDR)
        `SGIO_A_DIR:  RDATA <= {9'h000, dir};
        `SGIO_A_OUT:  RDATA <= {9'h000, out_lvl};
        `SGIO_A_DEB:  RDATA <= {9'h000, filt};
        `SGIO_A_KILL: RDATA <= {6'h00, kill_cfg};
        `SGIO_A_STOP: RDATA <= {12'h000, stop_cfg};
        `SGIO_A_ANA:  RDATA <= {12'h000, ana_en};
        `SGIO_A_HS:   RDATA <= {9'h000, HS_BUSY};
        `SGIO_A_STAT: RDATA <= {12'h000, status};
        `SGIO_A_MASK: RDATA <= {12'h000, mask};
        `SGIO_A_ASEL: RDATA <= {12'h000, asel};
        `SGIO_A_ADAT: RDATA <= ana_word;
        default:      RDATA <= 16'h0000;
      endcase
    end else begin
      RDATA <= 16'h0000;
    end
  end

  // ========================================================
  // checks
  logic [6:0] last_mask;
  always_ff @(posedge CLK_SYS) begin
    last_mask <= cmd_mask;
  end

  property p_reset_inputs;
    @(posedge CLK_SYS) !RESETN |=> (LINE_OE == 7'h00);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("line driven after reset");

  property p_config_out;
    @(posedge CLK_SYS) disable iff (!RESETN)
      cmd_ok && cmd_op == sgio_pkg::OP_CONFIG && WDATA[`SGIO_F_CMD_OUTPUT]
      |=> ((LINE_OE & last_mask) == last_mask)
          && (((LINE_OUT & last_mask) != 7'h00) == $past(WDATA[6]));
  endproperty
  a_config_out: assert property (p_config_out)
    else $error("config did not set output or level");

  property p_set_high;
    @(posedge CLK_SYS) disable iff (!RESETN)
      cmd_ok && cmd_op == sgio_pkg::OP_SET
      |=> ((LINE_OE & LINE_OUT & last_mask) == last_mask)
          && ((ana_en & last_mask[6:3]) == 4'h0);
  endproperty
  a_set_high: assert property (p_set_high)
    else $error("set command did not drive high");

  property p_clear_low;
    @(posedge CLK_SYS) disable iff (!RESETN)
      cmd_ok && cmd_op == sgio_pkg::OP_CLEAR
      |=> ((LINE_OE & last_mask) == last_mask)
          && ((LINE_OUT & last_mask) == 7'h00);
  endproperty
  a_clear_low: assert property (p_clear_low)
    else $error("clear command did not drive low");

  property p_hs_refused;
    @(posedge CLK_SYS) disable iff (!RESETN)
      cmd_err |=> $stable(LINE_OE) && $stable(LINE_OUT)
                  && status[`SGIO_ST_ERR];
  endproperty
  a_hs_refused: assert property (p_hs_refused)
    else $error("high-speed line was reassigned");

  property p_filter_on_tick;
    @(posedge CLK_SYS) disable iff (!RESETN)
      !$past(tick) |-> $stable(filt);
  endproperty
  a_filter_on_tick: assert property (p_filter_on_tick)
    else $error("filtered input moved between ticks");

  property p_kill_now;
    @(posedge CLK_SYS) disable iff (!RESETN)
      kill_cond |=> MOTOR_KILL && MOTION_STOP;
  endproperty
  a_kill_now: assert property (p_kill_now)
    else $error("kill not raised on trigger");

  property p_stop_plain;
    @(posedge CLK_SYS) disable iff (!RESETN)
      MOTION_STOP && !MOTOR_KILL |-> $past(stop_cond);
  endproperty
  a_stop_plain: assert property (p_stop_plain)
    else $error("stop raised without a valid input line");

endmodule
`default_nettype wire

// ==== tb/sgio_field_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side: switches, relays and analog sources on the lines
module sgio_field_model (
  input  wire logic        clk_sys,
  input  wire logic        servo_tick,
  input  wire logic [6:0]  ext_lvl,
  input  wire logic [6:0]  line_oe,
  input  wire logic [6:0]  line_out,
  input  wire logic [39:0] ana_set,
  output logic      [6:0]  line_in,
  output logic      [39:0] adc_line
);
  logic [9:0] hum = 10'h000;
  // a driven line reads back the device level, else the switch level
  assign line_in = (line_oe & line_out) | (~line_oe & ext_lvl);
  // common-mode hum flips every servo cycle so averaging is exercised
  always_ff @(posedge clk_sys) begin
    if (servo_tick)
      hum <= hum ^ 10'h010;
  end
  always_comb begin
    for (int i = 0; i < 4; i++)
      adc_line[i*10 +: 10] = ana_set[i*10 +: 10] + hum;
  end
endmodule
`default_nettype wire

// ==== tb/sgio_lines_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sgio_lines_tb_top;
  typedef struct {
    string       nm;
    logic [15:0] exp;
    logic [15:0] msk;
    int          tol;
  } sgio_note_t;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_q = 1'b0;
  logic [6:0]  hs = 7'h00;
  logic [6:0]  ext = 7'h00;
  logic [39:0] ana = 40'h0;
  logic [59:0] aint = 60'h0;
  logic [15:0] rdata, sn, em;
  logic [6:0]  lin, lout, loe;
  logic [39:0] aline;
  logic        tick, kill, stop, trig, irq;
  logic [31:0] seed = 32'h00017BDD;
  logic [9:0]  smp [10];
  int          fail_count = 0;
  int          tests_run = 0;
  int          trig_cnt = 0;
  int          cyc = 0;
  int          dv, t0, e;
  sgio_note_t  nt;
  sgio_note_t  notes[$];

  initial forever #12.5 clk = ~clk;

  sgio_lines #(.SERVO_CYCLES(8)) u_sgio_lines (.CLK_SYS(clk),
    .RESETN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .LINE_IN(lin), .LINE_OUT(lout), .LINE_OE(loe),
    .HS_BUSY(hs), .ADC_LINE(aline), .ADC_INT(aint), .SERVO_TICK(tick),
    .MOTOR_KILL(kill), .MOTION_STOP(stop), .SCALED_TRIG(trig), .IRQ(irq));
  sgio_field_model u_sgio_field_model (.clk_sys(clk), .servo_tick(tick),
    .ext_lvl(ext), .line_oe(loe), .line_out(lout), .ana_set(ana),
    .line_in(lin), .adc_line(aline));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] x, m,
                        input string nm, input int tol = 0);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    notes.push_back('{nm, x, m, tol});
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // returns just before the edge on which the servo tick is sampled
  task automatic wait_tick(input int n);
    repeat (n) begin
      @(negedge clk);
      while (tick !== 1'b1)
        @(negedge clk);
    end
  endtask
  task automatic bit_is(input string nm, input logic b, input logic x);
    check(nm, {15'h0, b}, {15'h0, x});
  endtask

  always @(posedge clk) begin
    rd_q <= rd;
    cyc <= cyc + 1;
    if (trig === 1'b1)
      trig_cnt <= trig_cnt + 1;
    if (cyc == 12000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_q && notes.size() > 0) begin
      nt = notes.pop_front();
      sn = rdata & nt.msk;
      em = nt.exp & nt.msk;
      dv = int'($signed(sn)) - int'($signed(em));
      if (^sn !== 1'bx && dv <= nt.tol && dv >= -nt.tol)
        sn = em;
      check(nt.nm, sn, em);
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("oe", {9'h0, loe}, 16'h0000);
    rd_reg(4'h0, 16'h0000, 16'hFFFF, "dir");
    rd_reg(4'hF, 16'h0000, 16'hFFFF, "unmapped");
    $display("test reset done");
    // ==========================================================
    // set, clear and configure one line each
    wr_reg(4'h1, 16'h0021);
    wr_reg(4'h1, 16'h0032);
    wr_reg(4'h1, 16'h00D3);
    @(negedge clk);
    check("oe", {9'h0, loe}, 16'h0007);
    check("out", {9'h0, lout}, 16'h0005);
    wr_reg(4'h1, 16'h0013);
    rd_reg(4'h0, 16'h0003, 16'hFFFF, "dir");
    rd_reg(4'h2, 16'h0001, 16'h0003, "out reg");
    wr_reg(4'h6, 16'h000F);
    wr_reg(4'h1, 16'h0024);
    rd_reg(4'h6, 16'h000E, 16'h000F, "ana en");
    wr_reg(4'h6, 16'h0000);
    $display("test outputs done");
    // ==========================================================
    // high-speed line refuses the output command
    hs <= 7'h10;
    wr_reg(4'h9, 16'h0008);
    wr_reg(4'h1, 16'h0035);
    @(negedge clk);
    bit_is("oe5", loe[4], 1'b0);
    bit_is("irq err", irq, 1'b1);
    rd_reg(4'h7, 16'h0010, 16'h007F, "hs");
    rd_reg(4'h8, 16'h0008, 16'h0008, "err");
    wr_reg(4'h8, 16'h0008);
    @(negedge clk);
    bit_is("irq clr", irq, 1'b0);
    // ==========================================================
    // stop ignores a line held by a high-speed function
    wr_reg(4'h5, 16'h000D);
    ext <= 7'h10;
    wait_tick(3);
    bit_is("stop hs", stop, 1'b0);
    hs <= 7'h00;
    wait_tick(3);
    bit_is("stop", stop, 1'b1);
    ext <= 7'h00;
    wr_reg(4'h5, 16'h0000);
    $display("test refusal done");
    // ==========================================================
    // kill on line 2 at both polarities, no debounce
    wr_reg(4'h1, 16'h0011);
    wr_reg(4'h1, 16'h0012);
    wr_reg(4'h9, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      wr_reg(4'h4, 16'h0002 | 16'(p << 5));
      ext <= {5'h0, ~p[0], 1'b0};
      wait_tick(2);
      wr_reg(4'h8, 16'h000F);
      @(negedge clk);
      bit_is("kill idle", kill, 1'b0);
      bit_is("irq idle", irq, 1'b0);
      ext <= {5'h0, p[0], 1'b0};
      wait_tick(1);
      @(negedge clk);
      bit_is("kill early", kill, 1'b0);
      @(negedge clk);
      bit_is("kill", kill, 1'b1);
      bit_is("kill stop", stop, 1'b1);
      @(negedge clk);
      bit_is("irq kill", irq, 1'b1);
    end
    wr_reg(4'h4, 16'h0000);
    ext <= 7'h00;
    $display("test kill done");
    // ==========================================================
    // line 1 trigger behind a three-tick debounce
    wr_reg(4'h4, 16'h0300);
    wr_reg(4'h3, 16'h0301);
    wait_tick(3);
    t0 = trig_cnt;
    ext <= 7'h01;
    wait_tick(1);
    rd_reg(4'h3, 16'h0000, 16'h0001, "filt early");
    check("trig early", 16'(trig_cnt - t0), 16'h0000);
    wait_tick(3);
    rd_reg(4'h3, 16'h0001, 16'h0001, "filt");
    // the trigger pulse is registered after the filter moves, then counted
    repeat (2) @(negedge clk);
    check("trig", 16'(trig_cnt - t0), 16'h0001);
    $display("test debounce done");
    // ==========================================================
    // all twelve averaged channels
    wr_reg(4'h1, 16'h0014);
    wr_reg(4'h6, 16'h000F);
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      smp[i] = 10'(seed % 1000);
    end
    ana <= {smp[3], smp[2], smp[1], smp[0]};
    aint <= {smp[9], smp[8], smp[7], smp[6], smp[5], smp[4]};
    wait_tick(400);
    for (int c = 0; c < 12; c++) begin
      e = c < 4 ? (int'(smp[c]) + 8) * 32 :
          c < 6 ? (int'(smp[2*c-8]) - int'(smp[2*c-7])) * 32 :
          int'(smp[c-2]) * 32;
      wr_reg(4'hA, 16'(c));
      rd_reg(4'hB, 16'(e), 16'hFFFF, "adat", c < 4 ? 320 : 64);
    end
    $display("test analog done");
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
